// [hdl/uobd_pkg.sv]
// package: option byte layout, register map and timing of the option decoder
package uobd_pkg;

   // system clock
   localparam int unsigned CLK_HZ = 50_000_000;

   // reset load: counter width, flash reads, option byte addresses
   localparam int unsigned LOAD_CNT_W = 6;
   localparam int unsigned LOAD_CYCLES = 43;
   localparam logic [5:0] OPT0_FLASH_ADDR = 6'h00;
   localparam logic [5:0] OPT1_FLASH_ADDR = 6'h01;
   localparam int unsigned FLASH_AW = 16;

   // value of an erased option byte
   localparam logic [7:0] OPT_ERASED = 8'hff;

   // option byte 0 fields
   localparam int OB0_WDT_ACTION = 7;
   localparam int OB0_WATCHDOG_ALWAYS_ON_N_N = 6;
   localparam int OB0_OSC_HI = 5;
   localparam int OB0_OSC_LO = 4;
   localparam int OB0_BO_STOP = 3;
   localparam int OB0_READ_N = 2;
   localparam int OB0_WRITE_N = 0;

   // option byte 1 fields
   localparam int OB1_BO_RESET = 7;
   localparam int OB1_XTAL_OFF = 4;

   // crystal settle time added to reset while the crystal runs
   localparam int unsigned XTAL_SETTLE_NS = 1000;
   localparam int unsigned XTAL_SETTLE_CYC = (XTAL_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   // register map
   localparam int unsigned AXI_AW = 8;
   localparam logic [7:0] REG_CTRL_OFF = 8'h00;
   localparam logic [7:0] REG_STAT_OFF = 8'h04;
   localparam int CTRL_WDT_START = 0;
   localparam int CTRL_CLK_XTAL = 1;
   localparam int CTRL_GIE = 2;
   localparam int STAT_BUSY = 0;
   localparam int STAT_WDT_RUN = 1;
   localparam int STAT_CLK_XTAL = 2;
   localparam int STAT_WDT_PEND = 3;
   localparam logic CTRL_RESET = 1'b0;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // oscillator drive modes
   typedef enum logic [1:0] {
      OSC_EXT_RC = 2'b00,
      OSC_XTAL_LOW = 2'b01,
      OSC_XTAL_MED = 2'b10,
      OSC_XTAL_HIGH = 2'b11
   } uobd_osc_e;

   // loader states, gray along read, drain, settle, run
   typedef enum logic [1:0] {
      LD_READ = 2'b00,
      LD_DRAIN = 2'b01,
      LD_SETTLE = 2'b11,
      LD_RUN = 2'b10
   } uobd_load_e;

endpackage : uobd_pkg

// [hdl/uobd_loader.sv]
// reset-time loader that reads the option bytes from flash
`timescale 1ns/1ps
module uobd_loader import uobd_pkg::*; #(
   parameter int unsigned CNT_W = LOAD_CNT_W,
   parameter int unsigned CYCLES = LOAD_CYCLES,
   parameter int unsigned SETTLE = XTAL_SETTLE_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // stop-mode recovery reload
   input wire logic reload,
   // flash read port, data one cycle after the read
   output logic [CNT_W-1:0] flash_addr,
   output logic flash_rd,
   input wire logic [7:0] flash_rdata,
   // loaded option bytes and progress
   output logic [7:0] opt0,
   output logic [7:0] opt1,
   output logic busy
);

   // the counter must reach every read
   if (CYCLES < 2 || CYCLES > (1 << CNT_W) || SETTLE < 1 || SETTLE > (1 << 16)) begin : g_chk
      $error("uobd_loader: counters cannot serve the read or settle count");
   end

   uobd_load_e state_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [15:0] settle_reg;
   logic rd_d_reg;
   logic [CNT_W-1:0] addr_d_reg;

   assign flash_addr = cnt_reg;
   assign flash_rd = (state_reg == LD_READ);
   assign busy = (state_reg != LD_RUN);

   // sequence: one read per cycle, drain, optional crystal settle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= LD_READ;
         cnt_reg <= '0;
         settle_reg <= '0;
      end else begin
         unique case (state_reg)
            LD_READ: begin
               cnt_reg <= cnt_reg + 1'b1;
               if (cnt_reg == CNT_W'(CYCLES - 1)) begin
                  state_reg <= LD_DRAIN;
               end
            end
            LD_DRAIN: begin
               settle_reg <= '0;
               state_reg <= opt1[OB1_XTAL_OFF] ? LD_RUN : LD_SETTLE;
            end
            LD_SETTLE: begin
               settle_reg <= settle_reg + 1'b1;
               if (settle_reg == 16'(SETTLE - 1)) begin
                  state_reg <= LD_RUN;
               end
            end
            LD_RUN: begin
               cnt_reg <= '0;
               if (reload) begin
                  state_reg <= LD_READ;
               end
            end
         endcase
      end
   end

   // capture bytes at flash addresses 0 and 1, erased value at reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_d_reg <= 1'b0;
         addr_d_reg <= '0;
         opt0 <= OPT_ERASED;
         opt1 <= OPT_ERASED;
      end else begin
         rd_d_reg <= flash_rd;
         addr_d_reg <= cnt_reg;
         if (rd_d_reg && addr_d_reg == CNT_W'(OPT0_FLASH_ADDR)) begin
            opt0 <= flash_rdata;
         end
         if (rd_d_reg && addr_d_reg == CNT_W'(OPT1_FLASH_ADDR)) begin
            opt1 <= flash_rdata;
         end
      end
   end

   localparam int LAST = CYCLES - 1;

   chk_read_burst: assert property (@(posedge aclk) disable iff (!aresetn)
      flash_rd && cnt_reg == CNT_W'(LAST) |=> !flash_rd)
      else $error("read burst did not stop after the last read");
   chk_read_start: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(flash_rd) |-> cnt_reg == '0 ##1 flash_rd[*2])
      else $error("read burst did not start at address zero");

endmodule : uobd_loader

// [hdl/uobd_axil.sv]
// axi4-lite slave for the control and status words
`timescale 1ns/1ps
module uobd_axil import uobd_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address and data
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address and data
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // block side
   input wire logic [31:0] ctrl_word,
   input wire logic [31:0] stat_word,
   output logic ctrl_wr,
   output logic [31:0] ctrl_wdata
);

   logic aw_have_reg;
   logic w_have_reg;
   logic [AXI_AW-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic wlane0_reg;

   function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
      return (a == REG_CTRL_OFF) || (a == REG_STAT_OFF);
   endfunction : is_mapped

   assign s_axi_awready = aresetn && !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready = aresetn && !w_have_reg && !s_axi_bvalid;
   assign s_axi_arready = aresetn && !s_axi_rvalid;

   // write side: address and data in either order, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wlane0_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         ctrl_wr <= 1'b0;
         ctrl_wdata <= '0;
      end else begin
         ctrl_wr <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wlane0_reg <= s_axi_wstrb[0];
         end
         if (aw_have_reg && w_have_reg) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
            ctrl_wr <= (awaddr_reg == REG_CTRL_OFF) && wlane0_reg;
            ctrl_wdata <= wdata_reg;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read side: answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         s_axi_rdata <= (s_axi_araddr == REG_CTRL_OFF) ? ctrl_word :
                        (s_axi_araddr == REG_STAT_OFF) ? stat_word : '0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : uobd_axil

// [hdl/uobd_top.sv]
// option byte decoder: reset load, decode and device steering
`timescale 1ns/1ps

// Operation
// - option0 bit7 picks watchdog interrupt or reset
// - watchdog interrupt reaches cpu only when enabled
// - bit6 low starts watchdog, never stoppable
// - bit6 high: started by instruction, reset stops
// - bits5:4 select oscillator drive mode
// - bit3 keeps brown-out active in stop
// - bit2 low blocks code reads, limited debug
// - bit2 high allows code reads, full debug
// - bit0 low refuses user program/erase, debugger mass-erase
// - bit0 high allows all program and erase
// - option1 bit7 makes brown-out cause reset
// - crystal bit enables only, software selects clock
// - bit4 low runs crystal, longer reset
// - erased bytes give the documented defaults
// - reset never alters stored option bytes
// - every reset reloads options before execution
// - 43 counted reads, options at addresses 0,1
// - option latches invisible to software
module uobd_top import uobd_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite register bus
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // flash read port used by the reset load
   output logic [FLASH_AW-1:0] flash_addr,
   output logic flash_rd,
   input wire logic [7:0] flash_rdata,
   // reset sequencing
   input wire logic stop_recovery,
   output logic core_hold,
   // watchdog
   input wire logic watchdog_timeout,
   input wire logic watchdog_irq_ack,
   output logic watchdog_enable,
   output logic watchdog_irq,
   // system reset request and brown-out
   input wire logic brownout_detect,
   input wire logic stop_mode,
   output logic brownout_enable,
   output logic sys_reset_req,
   // oscillator
   output uobd_osc_e oscillator_drive_select,
   output logic crystal_enable,
   output logic clk_sel_crystal,
   // flash protection
   input wire logic user_prog_req,
   input wire logic user_page_erase_req,
   input wire logic user_mass_erase_req,
   input wire logic dbg_mass_erase_req,
   output logic prog_grant,
   output logic page_erase_grant,
   output logic mass_erase_grant,
   output logic flash_refused,
   output logic code_read_enable,
   output logic dbg_full_access
);

   logic [LOAD_CNT_W-1:0] ld_addr;
   logic ld_rd;
   logic ld_busy;
   logic [7:0] opt0;
   logic [7:0] opt1;
   logic ctrl_wr;
   logic [31:0] ctrl_wdata;
   logic [31:0] ctrl_word;
   logic [31:0] stat_word;

   // decoded option fields and derived control terms
   logic watchdog_timeout_action;
   logic watchdog_always_on_n;
   logic brownout_keep_in_stop;
   logic code_read_protect_n;
   logic flash_write_protect_n;
   logic brownout_reset_enable;
   logic crystal_off_in_reset;
   logic watchdog_start_instruction;
   logic bo_active;
   logic wdt_hit;

   // control and state
   logic wdt_run_reg;
   logic wdt_pend_reg;
   logic gie_reg;
   logic clk_xtal_reg;
   logic xtal_on_reg;

   uobd_loader #(
      .CNT_W(LOAD_CNT_W),
      .CYCLES(LOAD_CYCLES),
      .SETTLE(XTAL_SETTLE_CYC)
   ) u_loader (
      .aclk(aclk),
      .aresetn(aresetn),
      .reload(stop_recovery),
      .flash_addr(ld_addr),
      .flash_rd(ld_rd),
      .flash_rdata(flash_rdata),
      .opt0(opt0),
      .opt1(opt1),
      .busy(ld_busy)
   );

   uobd_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .ctrl_word(ctrl_word),
      .stat_word(stat_word),
      .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata)
   );

   // flash address: counter in the low bits, the rest zero
   assign flash_addr = {{(FLASH_AW - LOAD_CNT_W){1'b0}}, ld_addr};
   assign flash_rd = ld_rd;

   // field decode from the option latches, then the start instruction and derived watchdog and brown-out terms
   assign watchdog_timeout_action = opt0[OB0_WDT_ACTION];
   assign watchdog_always_on_n = opt0[OB0_WATCHDOG_ALWAYS_ON_N_N];
   assign brownout_keep_in_stop = opt0[OB0_BO_STOP];
   assign code_read_protect_n = opt0[OB0_READ_N];
   assign flash_write_protect_n = opt0[OB0_WRITE_N];
   assign brownout_reset_enable = opt1[OB1_BO_RESET];
   assign crystal_off_in_reset = opt1[OB1_XTAL_OFF];
   assign watchdog_start_instruction = ctrl_wr && ctrl_wdata[CTRL_WDT_START];
   assign bo_active = brownout_keep_in_stop || !stop_mode;
   assign wdt_hit = watchdog_timeout && wdt_run_reg && !ld_busy;

   // register words; option latches never appear here
   assign ctrl_word = {29'h0, gie_reg, clk_xtal_reg, 1'b0};
   assign stat_word = {28'h0, wdt_pend_reg, clk_xtal_reg, wdt_run_reg, core_hold};

   // core held until the load and any crystal settle finish
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_hold <= 1'b1;
      end else begin
         core_hold <= ld_busy;
      end
   end

   // software control bits, writable only once the core runs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gie_reg <= CTRL_RESET;
         clk_xtal_reg <= CTRL_RESET;
      end else if (ctrl_wr && !ld_busy) begin
         gie_reg <= ctrl_wdata[CTRL_GIE];
         clk_xtal_reg <= ctrl_wdata[CTRL_CLK_XTAL];
      end
   end

   // watchdog run: auto start or instruction start, cleared by reset only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_run_reg <= 1'b0;
      end else if (!ld_busy && !watchdog_always_on_n) begin
         wdt_run_reg <= 1'b1;
      end else if (!ld_busy && watchdog_start_instruction) begin
         wdt_run_reg <= 1'b1;
      end
   end

   // watchdog interrupt pending, a new time-out wins over the ack
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_pend_reg <= 1'b0;
         watchdog_irq <= 1'b0;
      end else begin
         if (wdt_hit && !watchdog_timeout_action) begin
            wdt_pend_reg <= 1'b1;
         end else if (watchdog_irq_ack) begin
            wdt_pend_reg <= 1'b0;
         end
         watchdog_irq <= wdt_pend_reg && gie_reg;
      end
   end

   // watchdog state out and system reset request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_enable <= 1'b0;
         sys_reset_req <= 1'b0;
      end else begin
         watchdog_enable <= wdt_run_reg;
         sys_reset_req <= (wdt_hit && watchdog_timeout_action)
            || (!ld_busy && brownout_detect && bo_active && brownout_reset_enable);
      end
   end

   // brown-out enable, oscillator mode, read protection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         brownout_enable <= 1'b1;
         oscillator_drive_select <= OSC_XTAL_HIGH;
         code_read_enable <= 1'b1;
         dbg_full_access <= 1'b1;
      end else begin
         brownout_enable <= bo_active;
         oscillator_drive_select <= uobd_osc_e'(opt0[OB0_OSC_HI:OB0_OSC_LO]);
         code_read_enable <= code_read_protect_n;
         dbg_full_access <= code_read_protect_n;
      end
   end

   // flash program and erase gating
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prog_grant <= 1'b0;
         page_erase_grant <= 1'b0;
         mass_erase_grant <= 1'b0;
         flash_refused <= 1'b0;
      end else begin
         prog_grant <= user_prog_req && flash_write_protect_n && !ld_busy;
         page_erase_grant <= user_page_erase_req && flash_write_protect_n && !ld_busy;
         mass_erase_grant <= (user_mass_erase_req && flash_write_protect_n && !ld_busy)
            || dbg_mass_erase_req;
         flash_refused <= (user_prog_req || user_page_erase_req || user_mass_erase_req)
            && !flash_write_protect_n;
      end
   end

   // crystal: on during reset unless disabled, software may turn it on
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xtal_on_reg <= 1'b0;
      end else if (ld_busy) begin
         xtal_on_reg <= !crystal_off_in_reset;
      end else if (ctrl_wr && ctrl_wdata[CTRL_CLK_XTAL]) begin
         xtal_on_reg <= 1'b1;
      end
   end

   assign crystal_enable = xtal_on_reg;
   assign clk_sel_crystal = clk_xtal_reg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_wdt_reset_route: assert property (
      wdt_hit && watchdog_timeout_action |=> sys_reset_req)
      else $error("watchdog time-out did not request reset");
   chk_wdt_irq_route: assert property (
      wdt_hit && !watchdog_timeout_action |=> wdt_pend_reg ##1 (watchdog_irq == gie_reg || $changed(gie_reg)))
      else $error("watchdog time-out did not raise interrupt");
   chk_irq_gated: assert property (
      watchdog_irq |-> $past(gie_reg) && $past(wdt_pend_reg))
      else $error("interrupt passed while disabled");
   chk_wdt_auto_on: assert property (
      !ld_busy && !watchdog_always_on_n |=> wdt_run_reg ##1 watchdog_enable)
      else $error("always-on watchdog not started");
   chk_wdt_no_stop: assert property (
      wdt_run_reg |=> wdt_run_reg)
      else $error("running watchdog stopped without reset");
   chk_wdt_start_cause: assert property (
      $rose(wdt_run_reg) |-> $past(!watchdog_always_on_n || watchdog_start_instruction))
      else $error("watchdog started without cause");
   chk_osc_mode: assert property (
      1'b1 |=> oscillator_drive_select == $past(opt0[OB0_OSC_HI:OB0_OSC_LO]))
      else $error("oscillator mode does not follow option");
   chk_bo_stop: assert property (
      stop_mode && !brownout_keep_in_stop |=> !brownout_enable)
      else $error("brown-out left on in stop mode");
   chk_read_protect: assert property (
      !code_read_protect_n ##1 !code_read_protect_n |-> !code_read_enable && !dbg_full_access)
      else $error("protected code left readable");
   chk_write_protect: assert property (
      prog_grant || page_erase_grant |-> $past(flash_write_protect_n))
      else $error("program or erase granted while protected");
   chk_dbg_mass: assert property (
      dbg_mass_erase_req |=> mass_erase_grant)
      else $error("debugger mass erase not carried out");
   chk_bo_reset: assert property (
      !ld_busy && brownout_detect && bo_active && brownout_reset_enable |=> sys_reset_req)
      else $error("brown-out did not request reset");
   chk_clk_sel_sw: assert property (
      $rose(clk_sel_crystal) |-> $past(ctrl_wr))
      else $error("clock switched to crystal without software");
   chk_xtal_in_reset: assert property (
      ld_busy && !crystal_off_in_reset |=> crystal_enable)
      else $error("crystal off during reset load");
   chk_opts_stable: assert property (
      !ld_busy ##1 !ld_busy |-> $stable(opt0) && $stable(opt1))
      else $error("options changed outside reset");
   chk_hold_release: assert property (
      $fell(core_hold) |-> $past(!ld_busy, 1) && !ld_busy)
      else $error("core released before load finished");
   chk_erased_defaults: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> oscillator_drive_select == OSC_XTAL_HIGH && brownout_enable && code_read_enable && core_hold)
      else $error("reset values differ from erased defaults");

   cov_load_done: cover property ($fell(core_hold));
   cov_wdt_irq: cover property (watchdog_irq);
   cov_reset_req: cover property (sys_reset_req);
   cov_refused: cover property (flash_refused);

endmodule : uobd_top

// [verification/tb_top.sv]
// self-checking bench for the option byte decoder
`timescale 1ns/1ps
module tb_top;
   import uobd_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, stop_mode = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [15:0] flash_addr;
   logic [7:0] flash_rdata = 8'h00, ob0 = 8'hff, ob1 = 8'hff, pin = 8'h00;
   logic flash_rd, stop_recovery, brownout_detect, watchdog_timeout, watchdog_irq_ack;
   logic dbg_mass_erase_req, user_mass_erase_req, user_page_erase_req, user_prog_req;
   logic core_hold, watchdog_enable, watchdog_irq, brownout_enable, sys_reset_req;
   logic crystal_enable, clk_sel_crystal, prog_grant, page_erase_grant, mass_erase_grant;
   logic flash_refused, code_read_enable, dbg_full_access;
   uobd_osc_e oscillator_drive_select;
   logic [4:0] seen = 5'h00;
   int rd_n = 0, fails = 0, check_count = 0, n1, n2, n3;
   wire [7:0] cfg = {oscillator_drive_select, brownout_enable, code_read_enable, dbg_full_access,
      watchdog_enable, crystal_enable, clk_sel_crystal};
   // request pulses share one vector
   assign {stop_recovery, brownout_detect, watchdog_timeout, watchdog_irq_ack, dbg_mass_erase_req,
      user_mass_erase_req, user_page_erase_req, user_prog_req} = pin;

   uobd_top uobd_top_i (.*);

   // clock
   always #10 aclk = ~aclk;

   // flash model, read counter and sticky record of one-cycle answers
   always @(posedge aclk) begin
      flash_rdata <= flash_addr[5:0] == OPT0_FLASH_ADDR ? ob0 :
         (flash_addr[5:0] == OPT1_FLASH_ADDR ? ob1 : ~flash_addr[7:0]);
      rd_n <= aresetn ? rd_n + int'(flash_rd) : 0;
      seen <= |pin ? 5'h00 : seen | {sys_reset_req, flash_refused, mass_erase_grant, page_erase_grant, prog_grant};
   end

   task automatic check(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic summarize();
      if (fails == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   task automatic run_wait(output int n);
      for (n = 0; n < 300 && core_hold !== 1'b0; n++) @(negedge aclk);
      repeat (2) @(posedge aclk);  // let outputs launched at the release edge settle
      if (n == 300) begin
         fails++;
         summarize();
      end
   endtask : run_wait

   task automatic boot(input logic [7:0] b0, b1, output int n);
      ob0 <= b0;
      ob1 <= b1;
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      run_wait(n);
      check(rd_n, LOAD_CYCLES);
   endtask : boot

   // one register access; ready sampled before the edge that takes it
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      logic ta, tw, tr, done = 1'b0;
      @(posedge aclk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
      end
      while (!done && n < 50) begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tr = s_axi_arvalid & s_axi_arready;
         done = w ? s_axi_bvalid : s_axi_rvalid;
         q = s_axi_rdata;
         r = w ? s_axi_bresp : s_axi_rresp;
         n++;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
      end
      if (!done) begin
         fails++;
         summarize();
      end
   endtask : bus

   // one-cycle request, then compare the answers seen
   task automatic pulse(input logic [7:0] m, input logic [4:0] e);
      @(posedge aclk);
      pin <= m;
      @(posedge aclk);
      pin <= 8'h00;
      repeat (3) @(negedge aclk);
      check(seen, e);
   endtask : pulse

   // erased bytes, every drive mode, then a programmed set
   initial begin
      boot(8'hff, 8'hff, n1);
      check(cfg, 8'hf8);
      bus(1'b1, REG_CTRL_OFF, 32'h1 << CTRL_WDT_START);
      check(r, RESP_OKAY);
      bus(1'b0, REG_STAT_OFF, 32'h0);
      check(q[STAT_WDT_RUN], 1'b1);
      pulse(8'h20, 5'h10);
      pulse(8'h40, 5'h10);
      for (int i = 0; i < 3; i++) pulse(8'h01 << i, 5'h01 << i);
      bus(1'b0, 8'h08, 32'h0);
      check(r, RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         boot({2'b11, i[1:0], 4'hf}, 8'hff, n3);
         check(oscillator_drive_select, i[1:0]);
      end
      boot(8'h12, 8'h6f, n2);
      check(n2 - n1, XTAL_SETTLE_CYC);
      check(cfg, 8'h66);
      for (int i = 0; i < 3; i++) pulse(8'h01 << i, 5'h08);
      pulse(8'h08, 5'h04);
      pulse(8'h20, 5'h00);
      check(watchdog_irq, 1'b0);
      bus(1'b1, REG_CTRL_OFF, 32'h1 << CTRL_GIE | 32'h1 << CTRL_CLK_XTAL);
      repeat (3) @(negedge aclk);
      check(watchdog_irq, 1'b1);
      check(clk_sel_crystal, 1'b1);
      pulse(8'h10, 5'h00);
      check(watchdog_irq, 1'b0);
      @(posedge aclk);
      stop_mode <= 1'b1;
      ob0 <= 8'hff;
      repeat (3) @(negedge aclk);
      check(brownout_enable, 1'b0);
      check(cfg[7:6], 2'b01);
      pulse(8'h80, 5'h00);
      run_wait(n3);
      check(rd_n, 2 * LOAD_CYCLES);
      check(oscillator_drive_select, OSC_XTAL_HIGH);
      summarize();
   end
endmodule : tb_top
